/* pkg/txsync_pkg.sv */
package txsync_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_TX_CTRL   = 8'h00;
  localparam logic [7:0] OFF_GCLK_CTRL = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;
  localparam logic [7:0] OFF_INT_STAT  = 8'h0C;
  localparam logic [7:0] OFF_INT_CLR   = 8'h10;
  localparam logic [7:0] OFF_INT_EN    = 8'h14;

  // tx_ctrl field positions
  localparam int CB_ES_EN    = 0;
  localparam int CB_SRC_INT  = 1;
  localparam int CB_LEGACY   = 2;
  localparam int CB_IBO      = 3;
  localparam int CB_SYNC_OUT = 4;
  localparam int CB_MF_SEL   = 5;
  localparam int CB_DOUBLE   = 6;
  localparam int CB_T1       = 7;
  localparam int CB_SSYNC_OUT = 8;
  localparam int CB_RATE_LO  = 9;
  localparam int CTRL_W      = 12;
  localparam logic [CTRL_W-1:0] TX_CTRL_RESET = 12'h000;

  // global_clock_ctrl_reg indication select
  localparam logic [1:0] IND_ANALOG = 2'h0;
  localparam logic [1:0] IND_RX_SIGNALING_FREEZE_OUT  = 2'h1;
  localparam logic [1:0] IND_FRAMER = 2'h2;
  localparam logic [1:0] GCLK_RESET = 2'h0;

  // Interrupt bits
  localparam int INT_LINE_ALIGN = 0;
  localparam int INT_SYS_ALIGN  = 1;
  localparam int INT_RATE_ERR   = 2;
  localparam int INT_W          = 3;
  localparam logic [INT_W-1:0] INT_RESET = 3'h0;

  // System clock rates by code, and frame rate
  localparam int SYSCLK_KHZ [5] = '{1544, 2048, 4096, 8192, 16384};
  localparam logic [2:0] RATE_4096 = 3'h2;
  localparam logic [2:0] RATE_MAX  = 3'h4;
  localparam int FRAME_KHZ = 8;

  // Frame geometry
  localparam int FB_W = 11;
  localparam int MF_W = 5;
  localparam logic [FB_W-1:0] T1_BITS = 11'h0C1;
  localparam logic [FB_W-1:0] E1_BITS = 11'h100;
  localparam logic [MF_W-1:0] T1_MF_FRAMES = 5'h18;
  localparam logic [MF_W-1:0] E1_MF_FRAMES = 5'h10;
  localparam logic [MF_W-1:0] SIG_PERIOD = 5'h06;

  typedef enum logic [1:0] {SP_IDLE, SP_ONE, SP_TWO} sync_pulse_t;

  function automatic logic [FB_W-1:0] bits_per_frame(logic [2:0] code);
    logic [2:0] c;
    c = (code > RATE_MAX) ? RATE_MAX : code;
    return FB_W'(SYSCLK_KHZ[c] / FRAME_KHZ);
  endfunction

endpackage

/* pkg/frame_cnt_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface frame_cnt_if;
  logic        tick;
  logic        align;
  logic [10:0] frame_bits;
  logic [4:0]  mf_frames;
  logic        at_frame;
  logic        at_mf;
  logic        at_sig;
  modport counter (input tick, align, frame_bits, mf_frames,
                   output at_frame, at_mf, at_sig);
  modport user (output tick, align, frame_bits, mf_frames,
                input at_frame, at_mf, at_sig);
endinterface
`default_nettype wire

/* src/edge_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module edge_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q,
  output logic      rise,
  output logic      fall
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign q    = s2;
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;
endmodule
`default_nettype wire

/* src/frame_counter.sv */
`timescale 1ns/1ns
`default_nettype none
module frame_counter
  import txsync_pkg::*;
(
  input wire logic    clk,
  input wire logic    rst_n,
  frame_cnt_if.counter fc
);
  logic [FB_W-1:0] bit_cnt;
  logic [MF_W-1:0] frm_cnt;
  // Shrinking frame length must not let the count run on to wraparound
  wire last_bit = (bit_cnt >= fc.frame_bits - 11'h001);
  wire last_frm = (frm_cnt == fc.mf_frames - 5'h01);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 11'h000;
      frm_cnt <= 5'h00;
    end else if (fc.tick) begin
      if (fc.align) begin
        bit_cnt <= 11'h000;
        frm_cnt <= 5'h00;
      end else if (last_bit) begin
        bit_cnt <= 11'h000;
        frm_cnt <= last_frm ? 5'h00 : frm_cnt + 5'h01;
      end else begin
        bit_cnt <= bit_cnt + 11'h001;
      end
    end
  end

  assign fc.at_frame = (bit_cnt == 11'h000);
  assign fc.at_mf    = fc.at_frame && (frm_cnt == 5'h00);
  // Every sixth frame carries signaling in T1
  assign fc.at_sig = (frm_cnt % SIG_PERIOD) == SIG_PERIOD - 5'h01;

  a_align_zero: assert property (@(posedge clk) disable iff (!rst_n)
    fc.tick && fc.align |=> bit_cnt == 11'h000 && frm_cnt == 5'h00)
    else $error("frame counter not realigned");
endmodule
`default_nettype wire

/* src/tx_system_clock_sync_select.sv */
// Contract
// - Internal source takes line clock from recovered clock
// - System clock used only with elastic store
// - Interleaved mode needs system clock 4.096MHz or above
// - Legacy mode: port 1 system clock serves all
// - Shared pins show selected loss or freeze indication
// - Shared pin outputs enabled only in legacy mode
// - Analog loss from front end, framer loss per port
// - Input line sync aligns transmit frame boundary
// - Output line sync marks frame or multiframe
// - T1 frame pulse may widen at signaling frames
// - Line sync timed to transmit line clock
// - Elastic store uses system sync instead of line
// - System sync timed to system clock
// - System sync output: 8kHz on backplane clock
// - Serial data sampled on falling governing clock
`timescale 1ns/1ns
`default_nettype none
module tx_system_clock_sync_select
  import txsync_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        transmit_line_clock,
  input  wire logic        recovered_rx_clock,
  input  wire logic        transmit_system_clock_p1,
  input  wire logic        transmit_system_clock,
  input  wire logic        backplane_clock_out,
  input  wire logic        transmit_serial_in,
  input  wire logic        transmit_frame_sync_i,
  output logic             transmit_frame_sync_o,
  output logic             transmit_frame_sync_oe_n,
  input  wire logic        transmit_system_sync_io_i,
  output logic             transmit_system_sync_io_o,
  output logic             transmit_system_sync_io_oe_n,
  input  wire logic [6:0]  analog_loss_out,
  input  wire logic [6:0]  rx_signaling_freeze_out,
  input  wire logic [6:0]  framer_loss_out,
  output logic [6:0]       alt_indication_o,
  output logic [6:0]       alt_indication_oe_n,
  output logic             serial_data,
  output logic             serial_strobe,
  output logic             frame_boundary,
  output logic             irq
);
  logic [CTRL_W-1:0] tx_ctrl;
  logic [1:0]        gclk_ctrl;
  logic [INT_W-1:0]  int_stat;
  logic [INT_W-1:0]  int_en;
  logic              wr_pend;
  logic [7:0]        wr_addr;
  logic              line_pend;
  logic              line_prev;
  logic              sys_pend;
  logic              sys_prev;
  logic              rate_bad_q;
  logic [FB_W-1:0]   bp_cnt;
  logic              sso;
  sync_pulse_t       sp_state;
  sync_pulse_t       next_sp_state;

  // Synchronised pins
  logic tl_q, tl_rise, tl_fall;
  logic rx_q, rx_rise, rx_fall;
  logic s1_q, s1_rise, s1_fall;
  logic so_q, so_rise, so_fall;
  logic bp_q, bp_rise, bp_fall;
  logic ser_q, lsy_q, ssy_q;

  edge_sync u_tl (.clk(hclk), .rst_n(hresetn), .d(transmit_line_clock),
    .q(tl_q), .rise(tl_rise), .fall(tl_fall));
  edge_sync u_rx (.clk(hclk), .rst_n(hresetn), .d(recovered_rx_clock),
    .q(rx_q), .rise(rx_rise), .fall(rx_fall));
  edge_sync u_s1 (.clk(hclk), .rst_n(hresetn),
    .d(transmit_system_clock_p1), .q(s1_q), .rise(s1_rise),
    .fall(s1_fall));
  edge_sync u_so (.clk(hclk), .rst_n(hresetn), .d(transmit_system_clock),
    .q(so_q), .rise(so_rise), .fall(so_fall));
  edge_sync u_bp (.clk(hclk), .rst_n(hresetn), .d(backplane_clock_out),
    .q(bp_q), .rise(bp_rise), .fall(bp_fall));
  edge_sync u_ser (.clk(hclk), .rst_n(hresetn), .d(transmit_serial_in),
    .q(ser_q), .rise(), .fall());
  edge_sync u_lsy (.clk(hclk), .rst_n(hresetn), .d(transmit_frame_sync_i),
    .q(lsy_q), .rise(), .fall());
  edge_sync u_ssy (.clk(hclk), .rst_n(hresetn),
    .d(transmit_system_sync_io_i), .q(ssy_q), .rise(), .fall());

  // Control fields
  wire       es_en    = tx_ctrl[CB_ES_EN];
  wire       src_int  = tx_ctrl[CB_SRC_INT];
  wire       legacy   = tx_ctrl[CB_LEGACY];
  wire       interleaved_bus_mode      = tx_ctrl[CB_IBO];
  wire       sync_out = tx_ctrl[CB_SYNC_OUT];
  wire       mf_sel   = tx_ctrl[CB_MF_SEL];
  wire       dbl_en   = tx_ctrl[CB_DOUBLE];
  wire       t1_mode  = tx_ctrl[CB_T1];
  wire       ssy_out  = tx_ctrl[CB_SSYNC_OUT];
  wire [2:0] rate     = tx_ctrl[CB_RATE_LO +: 3];

  // Clock selection
  wire line_rise = src_int ? rx_rise : tl_rise;
  wire line_fall = src_int ? rx_fall : tl_fall;
  wire line_lvl  = src_int ? rx_q : tl_q;
  // Pin is ignored without the elastic store, as it should sit low
  wire sclk_rise = es_en & (legacy ? s1_rise : so_rise);
  wire sclk_fall = es_en & (legacy ? s1_fall : so_fall);
  wire sclk_lvl  = legacy ? s1_q : so_q;
  wire data_fall = es_en ? sclk_fall : line_fall;
  // Slower codes cannot share one stream; lock assumed from outside
  wire rate_bad  = interleaved_bus_mode && (rate < RATE_4096);

  // Sync inputs sampled on governing rising edge
  wire line_in_ok = !sync_out && !es_en;
  wire sys_in_ok  = !ssy_out && es_en;
  // Armed pulse dropped if the sync output setting changes before it lands, or a line pulse if the elastic store turns on; store off holds a system pulse
  wire line_align = line_rise && line_pend && line_in_ok;
  wire sys_align  = sclk_rise && sys_pend && sys_in_ok;

  frame_cnt_if lf ();
  frame_cnt_if sf ();
  assign lf.tick       = line_rise;
  assign lf.align      = line_align;
  assign lf.frame_bits = t1_mode ? T1_BITS : E1_BITS;
  assign lf.mf_frames  = t1_mode ? T1_MF_FRAMES : E1_MF_FRAMES;
  assign sf.tick       = sclk_rise;
  assign sf.align      = sys_align;
  assign sf.frame_bits = bits_per_frame(rate);
  assign sf.mf_frames  = lf.mf_frames;

  frame_counter u_lfc (.clk(hclk), .rst_n(hresetn), .fc(lf.counter));
  frame_counter u_sfc (.clk(hclk), .rst_n(hresetn), .fc(sf.counter));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_pend <= 1'h0;
      line_prev <= 1'h0;
    end else if (line_rise) begin
      line_prev <= lsy_q;
      line_pend <= line_in_ok && lsy_q && !line_prev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_pend <= 1'h0;
      sys_prev <= 1'h0;
    end else if (sclk_rise) begin
      sys_prev <= ssy_q;
      sys_pend <= sys_in_ok && ssy_q && !sys_prev;
    end
  end

  // Line sync output pulse
  wire sp_start = sync_out && line_rise && (mf_sel ? lf.at_mf : lf.at_frame);
  wire sp_wide  = t1_mode && dbl_en && !mf_sel && lf.at_sig;

  always_comb begin
    next_sp_state = sp_state;
    if (!sync_out) begin
      next_sp_state = SP_IDLE;
    end else if (sp_start) begin
      next_sp_state = sp_wide ? SP_TWO : SP_ONE;
    end else if (line_rise) begin
      case (sp_state)
        SP_TWO:  next_sp_state = SP_ONE;
        SP_ONE:  next_sp_state = SP_IDLE;
        default: next_sp_state = SP_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_state <= SP_IDLE;
    end else begin
      sp_state <= next_sp_state;
    end
  end

  assign transmit_frame_sync_o    = (sp_state != SP_IDLE);
  assign transmit_frame_sync_oe_n = !sync_out;

  // System sync output on the backplane clock
  wire ssy_drive = ssy_out && es_en;
  wire bp_last   = (bp_cnt >= sf.frame_bits - 11'h001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bp_cnt <= 11'h000;
      sso    <= 1'h0;
    end else if (!ssy_drive) begin
      bp_cnt <= 11'h000;
      sso    <= 1'h0;
    end else if (bp_rise) begin
      bp_cnt <= bp_last ? 11'h000 : bp_cnt + 11'h001;
      sso    <= bp_last;
    end
  end

  assign transmit_system_sync_io_o    = sso;
  assign transmit_system_sync_io_oe_n = !ssy_drive;

  // Shared indication pins
  wire [6:0] ind_sel = (gclk_ctrl == IND_RX_SIGNALING_FREEZE_OUT)  ? rx_signaling_freeze_out :
                       (gclk_ctrl == IND_FRAMER) ? framer_loss_out :
                       analog_loss_out;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alt_indication_o <= 7'h00;
    end else begin
      alt_indication_o <= legacy ? ind_sel : 7'h00;
    end
  end

  assign alt_indication_oe_n = {7{!legacy}};

  // Serial data capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_data    <= 1'h0;
      serial_strobe  <= 1'h0;
      frame_boundary <= 1'h0;
    end else begin
      serial_strobe  <= data_fall;
      frame_boundary <= es_en ? (sclk_rise && sf.at_frame)
                              : (line_rise && lf.at_frame);
      if (data_fall) begin
        serial_data <= ser_q;
      end
    end
  end

  // AHB-Lite slave, zero wait states
  wire        addr_ok = hsel && hready && htrans[1];
  wire [7:0]  a       = haddr[7:0];
  wire        wr_ctrl = wr_pend && (wr_addr == OFF_TX_CTRL);
  wire        wr_gclk = wr_pend && (wr_addr == OFF_GCLK_CTRL);
  wire        wr_clr  = wr_pend && (wr_addr == OFF_INT_CLR);
  wire        wr_en   = wr_pend && (wr_addr == OFF_INT_EN);
  wire [31:0] status  = {28'h0000000, sclk_lvl, line_lvl, rate_bad,
                         transmit_frame_sync_o};
  wire [31:0] rd_mux  =
    (a == OFF_TX_CTRL)   ? {20'h00000, tx_ctrl} :
    (a == OFF_GCLK_CTRL) ? {30'h00000000, gclk_ctrl} :
    (a == OFF_STATUS)    ? status :
    (a == OFF_INT_STAT)  ? {29'h00000000, int_stat} :
    (a == OFF_INT_EN)    ? {29'h00000000, int_en} : 32'h00000000;

  // Events: set beats clear in the same cycle
  wire [INT_W-1:0] ev  = {rate_bad && !rate_bad_q, sys_align, line_align};
  wire [INT_W-1:0] clr = wr_clr ? hwdata[INT_W-1:0] : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'h0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      wr_pend <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr <= a;
        hrdata  <= hwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ctrl    <= TX_CTRL_RESET;
      gclk_ctrl  <= GCLK_RESET;
      int_en     <= INT_RESET;
      int_stat   <= INT_RESET;
      rate_bad_q <= 1'h0;
    end else begin
      if (wr_ctrl) tx_ctrl <= hwdata[CTRL_W-1:0];
      if (wr_gclk) gclk_ctrl <= hwdata[1:0];
      if (wr_en) int_en <= hwdata[INT_W-1:0];
      int_stat   <= (int_stat & ~clr) | ev;
      rate_bad_q <= rate_bad;
    end
  end

  assign irq       = |(int_stat & int_en);
  assign hreadyout = 1'h1;
  assign hresp     = 1'h0;

  a_clk_source: assert property (@(posedge hclk) disable iff (!hresetn)
    src_int && tl_rise && !rx_rise |-> !line_rise)
    else $error("line clock taken from wrong source");
  a_sysclk_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !es_en |-> !sclk_rise && !sys_align)
    else $error("system clock used without elastic store");
  a_rate_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(rate_bad) |=> int_stat[INT_RATE_ERR])
    else $error("slow system clock in interleaved mode not flagged");
  a_alt_select: assert property (@(posedge hclk) disable iff (!hresetn)
    legacy && gclk_ctrl == IND_FRAMER |=>
      alt_indication_o == $past(framer_loss_out) || $changed(gclk_ctrl))
    else $error("framer loss not routed to shared pins");
  a_alt_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    !legacy |-> alt_indication_oe_n == 7'h7F && alt_indication_o == 7'h00 ||
      $past(legacy))
    else $error("shared pins driven outside legacy mode");
  a_es_line_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    es_en && !$past(line_in_ok) |-> !line_align)
    else $error("line sync used with elastic store");
  a_sso_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    transmit_system_sync_io_o |-> $past(ssy_drive))
    else $error("system sync pulse without enable");
  a_strobe_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    serial_strobe |-> $past(data_fall) && serial_data == $past(ser_q))
    else $error("serial data not captured on falling edge");
  a_line_event: assert property (@(posedge hclk) disable iff (!hresetn)
    line_align |=> int_stat[INT_LINE_ALIGN])
    else $error("line realign event lost");
  a_wide_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    sp_start && sp_wide |=> sp_state == SP_TWO)
    else $error("double wide sync pulse not started");
endmodule
`default_nettype wire

/* verif/backplane_model.sv */
`timescale 1ns/1ns
`default_nettype none
module backplane_model (
  input  wire logic es_on,
  input  wire logic line_run,
  input  wire logic ser_val,
  output logic      lclk,
  output logic      rclk,
  output logic      sclk,
  output logic      bpclk,
  output logic      lsync,
  output logic      ssync,
  output logic      ser
);
  logic lc;
  // Line clock runs free; stopped only to try internal sourcing
  assign lclk = lc & line_run;
  // Low while idle, and on line clock edges so nothing slips
  assign sclk = lc & es_on;
  initial begin
    lc = 1'b0;
    rclk = 1'b0;
    bpclk = 1'b0;
    lsync = 1'b0;
    ssync = 1'b0;
    ser = 1'b0;
    fork
      #3 forever #80 lc = ~lc;
      #41 forever #80 rclk = ~rclk;
      #7 forever #60 bpclk = ~bpclk;
    join
  end
  // Moves on the rise, away from the falling sample edge
  always @(posedge lc) ser <= ser_val;
  // High across exactly one line clock rise
  task automatic pulse_line();
    @(negedge lc) lsync = 1'b1;
    @(negedge lc) lsync = 1'b0;
  endtask
  // Same shape, timed to the system clock
  task automatic pulse_sys();
    @(negedge sclk) ssync = 1'b1;
    @(negedge sclk) ssync = 1'b0;
  endtask
endmodule
`default_nettype wire

/* verif/tx_system_clock_sync_select_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module tx_system_clock_sync_select_bench;
  import txsync_pkg::*;
  localparam logic [31:0] ES = 32'h1 << CB_ES_EN;
  localparam logic [31:0] LEG = 32'h1 << CB_LEGACY;
  localparam logic [31:0] INTERLEAVED_BUS_MODE = 32'h1 << CB_IBO;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        lclk, rclk, sclk, bpclk, lsync, ssync, ser, es_on;
  logic        line_run, ser_val, own_off, fs_o, fs_oe_n, ss_o, ss_oe_n;
  logic        sdata, sstrb, fb;
  logic [6:0]  al, rsf, fl, alt_o, alt_oe_n;
  int          fail_count, tests_run, lc, rc, bc, k;
  // Pin level from the device's enable: its output when enabled, else the partner's drive
  wire logic   fs_pin = (fs_oe_n === 1'b0) ? fs_o : lsync;
  wire logic   ss_pin = (ss_oe_n === 1'b0) ? ss_o : ssync;

  tx_system_clock_sync_select uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .transmit_line_clock(lclk),
    .recovered_rx_clock(rclk), .transmit_system_clock_p1(sclk),
    .transmit_system_clock(sclk & ~own_off),
    .backplane_clock_out(bpclk), .transmit_serial_in(ser),
    .transmit_frame_sync_i(fs_pin), .transmit_frame_sync_o(fs_o),
    .transmit_frame_sync_oe_n(fs_oe_n),
    .transmit_system_sync_io_i(ss_pin),
    .transmit_system_sync_io_o(ss_o),
    .transmit_system_sync_io_oe_n(ss_oe_n), .analog_loss_out(al),
    .rx_signaling_freeze_out(rsf), .framer_loss_out(fl),
    .alt_indication_o(alt_o), .alt_indication_oe_n(alt_oe_n),
    .serial_data(sdata), .serial_strobe(sstrb), .frame_boundary(fb),
    .irq(irq)
  );
  backplane_model partner (
    .es_on(es_on), .line_run(line_run), .ser_val(ser_val), .lclk(lclk),
    .rclk(rclk), .sclk(sclk), .bpclk(bpclk), .lsync(lsync),
    .ssync(ssync), .ser(ser)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge lclk) lc++;
  always @(posedge rclk) rc++;
  always @(posedge bpclk) bc++;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tmo(int n, int lim);
    if (n >= lim) begin
      check("wait", 32'h0, 32'h1);
      end_sim();
    end
  endtask
  // Master side of one single word transfer; rd holds read data
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
    tmo(n, 64);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
    tmo(n, 64);
    rd = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask
  function automatic logic pick(int w);
    case (w)
      0: return fb;
      1: return fs_o;
      2: return ss_o;
      default: return sstrb;
    endcase
  endfunction
  // Next low-to-high of a watched output, bounded
  task automatic wait_rise(int w);
    int n;
    n = 0;
    while (pick(w) !== 1'b0 && n < 9000) begin @(posedge hclk); n++; end
    while (pick(w) !== 1'b1 && n < 9000) begin @(posedge hclk); n++; end
    tmo(n, 9000);
  endtask

  task automatic t_regs();
    check("alt_oe_n", 32'(alt_oe_n), 32'h7F);
    check("fs_oe_n", 32'(fs_oe_n), 32'h1);
    check("ss_oe_n", 32'(ss_oe_n), 32'h1);
    check("hresp", 32'(hresp), 32'h0);
    rdc("tx_ctrl", OFF_TX_CTRL, 32'(TX_CTRL_RESET));
    rdc("int_en", OFF_INT_EN, 32'(INT_RESET));
    wr(8'h40, 32'hFFFFFFFF);
    rdc("unmapped", 8'h40, 32'h0);
  endtask
  task automatic t_line_sync();
    wr(OFF_INT_EN, 32'h1);
    partner.pulse_line();
    k = lc;
    wait_rise(0);
    // Boundary pulse marks the rise leaving bit 0, one after realign
    check("realign", 32'(lc), 32'(k + 2));
    k = lc;
    wait_rise(0);
    check("e1_frame", 32'(lc - k), 32'(E1_BITS));
    rdc("int_line", OFF_INT_STAT, 32'h1);
    check("irq_on", 32'(irq), 32'h1);
    wr(OFF_INT_CLR, 32'h1);
    @(posedge hclk);
    check("irq_clr", 32'(irq), 32'h0);
    wr(OFF_INT_EN, 32'h0);
    partner.pulse_line();
    wait_rise(0);
    rdc("int_mask", OFF_INT_STAT, 32'h1);
    check("irq_mask", 32'(irq), 32'h0);
    wr(OFF_TX_CTRL, 32'h1 << CB_T1);
    wait_rise(0);
    k = lc;
    wait_rise(0);
    check("t1_frame", 32'(lc - k), 32'(T1_BITS));
  endtask
  task automatic t_es();
    es_on <= 1'b1;
    wr(OFF_TX_CTRL, 32'h0);
    wr(OFF_INT_CLR, 32'h7);
    partner.pulse_sys();
    repeat (40) @(posedge hclk);
    rdc("sys_unused", OFF_INT_STAT, 32'h0);
    wr(OFF_TX_CTRL, ES);
    partner.pulse_line();
    repeat (40) @(posedge hclk);
    rdc("line_ignored", OFF_INT_STAT, 32'h0);
    partner.pulse_sys();
    k = lc;
    wait_rise(0);
    check("sys_realign", 32'(lc), 32'(k + 2));
    rdc("int_sys", OFF_INT_STAT, 32'h2);
    own_off <= 1'b1;
    wr(OFF_TX_CTRL, ES | LEG);
    partner.pulse_sys();
    k = lc;
    wait_rise(0);
    check("p1_clock", 32'(lc), 32'(k + 2));
    own_off <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      wr(OFF_TX_CTRL, ES | (32'h1 << CB_SSYNC_OUT) | (32'(c) << CB_RATE_LO));
      @(posedge hclk);
      check("ss_oe_n", 32'(ss_oe_n), 32'h0);
      wait_rise(2);
      k = bc;
      wait_rise(2);
      check("ss_period", 32'(bc - k), 32'(SYSCLK_KHZ[c] / FRAME_KHZ));
    end
    wr(OFF_TX_CTRL, 32'h0);
    es_on <= 1'b0;
  endtask
  task automatic t_fs_out();
    wr(OFF_TX_CTRL, 32'h1 << CB_SYNC_OUT);
    @(posedge hclk);
    check("fs_oe_n", 32'(fs_oe_n), 32'h0);
    wait_rise(1);
    k = lc;
    wait_rise(1);
    check("fs_period", 32'(lc - k), 32'(E1_BITS));
  endtask
  task automatic t_legacy();
    logic [6:0] e;
    for (int s = 0; s < 3; s++) begin
      e = (s == 0) ? al : (s == 1) ? rsf : fl;
      wr(OFF_GCLK_CTRL, 32'(s));
      wr(OFF_TX_CTRL, LEG);
      repeat (3) @(posedge hclk);
      check("alt_o", 32'(alt_o), 32'(e));
      check("alt_oe_n", 32'(alt_oe_n), 32'h0);
    end
    wr(OFF_TX_CTRL, 32'h0);
    repeat (3) @(posedge hclk);
    check("alt_off", 32'(alt_oe_n), 32'h7F);
  endtask
  task automatic t_rate();
    wr(OFF_INT_CLR, 32'h7);
    wr(OFF_TX_CTRL, INTERLEAVED_BUS_MODE);
    // Event flag lands one cycle after the control write
    @(posedge hclk);
    rdc("rate_err", OFF_INT_STAT, 32'h4);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("status_rate", 32'(rd[1]), 32'h1);
    wr(OFF_TX_CTRL, 32'h0);
    wr(OFF_INT_CLR, 32'h7);
    wr(OFF_TX_CTRL, INTERLEAVED_BUS_MODE | (32'(RATE_4096) << CB_RATE_LO));
    @(posedge hclk);
    rdc("rate_ok", OFF_INT_STAT, 32'h0);
    wr(OFF_TX_CTRL, 32'h0);
  endtask
  task automatic t_src();
    line_run <= 1'b0;
    wr(OFF_TX_CTRL, 32'h1 << CB_SRC_INT);
    wait_rise(0);
    k = rc;
    wait_rise(0);
    check("rcv_frame", 32'(rc - k), 32'(E1_BITS));
    line_run <= 1'b1;
    wr(OFF_TX_CTRL, 32'h0);
  endtask
  task automatic t_serial();
    for (int v = 1; v >= 0; v--) begin
      ser_val <= v[0];
      repeat (3) wait_rise(3);
      check("serial", 32'(sdata), 32'(v));
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    es_on = 1'b0;
    line_run = 1'b1;
    ser_val = 1'b0;
    own_off = 1'b0;
    al = 7'h15;
    rsf = 7'h2A;
    fl = 7'h4C;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_line_sync();
    t_es();
    t_fs_out();
    t_legacy();
    t_rate();
    t_src();
    t_serial();
    end_sim();
  end
endmodule
`default_nettype wire
